// ### logic/abs_pkg.sv
// constants, types and register map of the add/and/bit/skip execute block
// assumes one clock at the oscillator rate; the instruction cycle is derived
package abs_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int BUS_ADDR_W = 8;
  localparam int FILE_DEPTH = 128;

  // ****************************************
  // timing
  // ****************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h1;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

  // ****************************************
  // register map
  // ****************************************
  localparam logic [BUS_ADDR_W-1:0] ADDR_FILE_LAST = 8'h7F;
  localparam logic [BUS_ADDR_W-1:0] ADDR_ACC = 8'h80;
  localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 8'h81;
  localparam logic [BUS_ADDR_W-1:0] ADDR_CORE_STATE = 8'h82;

  // status fields
  localparam int STAT_CARRY = 0;
  localparam int STAT_NIBBLE = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_W = 3;
  // core state fields
  localparam int CORE_BUSY = 0;
  localparam int CORE_IDLE_SLOT = 1;

  // reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [STAT_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;

  // ****************************************
  // instruction set
  // ****************************************
  typedef enum logic [2:0] {
    add_literal_acc,
    add_acc_file,
    and_literal_acc,
    and_acc_file,
    bit_clear_file,
    bit_set_file,
    skip_if_bit_one,
    skip_if_bit_zero
  } abs_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SKIP
  } abs_state_t;

endpackage

// ### logic/abs_alu_if.sv
// carrier between the execute sequencer and its arithmetic unit
// assumes both ends sit on the same clock; the unit is purely combinational
`timescale 1ns/100ps
interface abs_alu_if;
  import abs_pkg::*;
  abs_op_t op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] literal;
  logic [BIT_W-1:0] bit_pos;
  logic dest_file;
  logic [DATA_W-1:0] result;
  logic carry;
  logic nibble_overflow;
  logic zero;
  logic upd_arith;
  logic upd_zero;
  logic to_acc;
  logic to_file;
  logic skip;

  modport core (output op, acc, file_val, literal, bit_pos, dest_file,
                input result, carry, nibble_overflow, zero, upd_arith,
                upd_zero, to_acc, to_file, skip);
  modport alu (input op, acc, file_val, literal, bit_pos, dest_file,
               output result, carry, nibble_overflow, zero, upd_arith,
               upd_zero, to_acc, to_file, skip);
endinterface

// ### logic/abs_alu.sv
// arithmetic, logic, bit and test unit for the execute block
// assumes operands are held stable by the sequencer for a whole cycle
`timescale 1ns/100ps
module abs_alu
  import abs_pkg::*;
(
  abs_alu_if.alu bus
);

  logic [DATA_W:0] sum;
  logic [4:0] low_sum;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] bit_mask;
  logic tested;

  always_comb begin
    operand = bus.file_val;
    if (bus.op == add_literal_acc || bus.op == and_literal_acc) begin
      operand = bus.literal;
    end
    bit_mask = 8'h01 << bus.bit_pos;
    tested = bus.file_val[bus.bit_pos];
    // [RULE11] carry sources
    sum = {1'b0, bus.acc} + {1'b0, operand};
    low_sum = {1'b0, bus.acc[3:0]} + {1'b0, operand[3:0]};
    bus.carry = sum[DATA_W];
    bus.nibble_overflow = low_sum[4];
    bus.result = sum[DATA_W-1:0];
    bus.upd_arith = 1'b0;
    bus.upd_zero = 1'b0;
    bus.to_acc = 1'b0;
    bus.to_file = 1'b0;
    bus.skip = 1'b0;
    unique case (bus.op)
      // [RULE1] literal add
      add_literal_acc: begin
        bus.upd_arith = 1'b1;
        bus.upd_zero = 1'b1;
        bus.to_acc = 1'b1;
      end
      // [RULE2] [RULE3] file add routed
      add_acc_file: begin
        bus.upd_arith = 1'b1;
        bus.upd_zero = 1'b1;
        bus.to_acc = ~bus.dest_file;
        bus.to_file = bus.dest_file;
      end
      // [RULE4] literal and
      and_literal_acc: begin
        bus.result = bus.acc & operand;
        bus.upd_zero = 1'b1;
        bus.to_acc = 1'b1;
      end
      // [RULE5] [RULE3] file and routed
      and_acc_file: begin
        bus.result = bus.acc & operand;
        bus.upd_zero = 1'b1;
        bus.to_acc = ~bus.dest_file;
        bus.to_file = bus.dest_file;
      end
      // [RULE6] clear one bit
      bit_clear_file: begin
        bus.result = bus.file_val & ~bit_mask;
        bus.to_file = 1'b1;
      end
      // [RULE7] set one bit
      bit_set_file: begin
        bus.result = bus.file_val | bit_mask;
        bus.to_file = 1'b1;
      end
      // [RULE8] skip on one
      skip_if_bit_one: begin
        bus.skip = tested;
      end
      // [RULE9] skip on zero
      skip_if_bit_zero: begin
        bus.skip = ~tested;
      end
    endcase
    // [RULE11] zero from result
    bus.zero = (bus.result == 8'h00);
  end

endmodule

// ### logic/add_and_bit_skip_execute.sv
// execute sequencer, accumulator, flags and file registers
// assumes instruction fields come from decode logic on the same clock
//
// Notes on behaviour
// [RULE1] add literal into accumulator, update flags
// [RULE2] add accumulator and file register, update flags
// [RULE3] destination zero accumulator, one file
// [RULE4] and literal into accumulator, zero only
// [RULE5] and with file, routed, zero only
// [RULE6] clear chosen bit, flags untouched
// [RULE7] set chosen bit, flags untouched
// [RULE8] bit one skips next, two cycles
// [RULE9] bit zero skips next, two cycles
// [RULE10] instruction cycle is four oscillator periods
// [RULE11] nibble carry bit3, carry bit7, zero
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module add_and_bit_skip_execute
  import abs_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] instr_op_in,
  input wire logic [FADDR_W-1:0] file_addr_in,
  input wire logic [BIT_W-1:0] bit_pos_in,
  input wire logic [DATA_W-1:0] literal_in,
  input wire logic dest_file_in,
  input wire logic [BUS_ADDR_W-1:0] bus_addr_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  output logic [DATA_W-1:0] bus_rdata_out,
  output logic ready_out,
  output logic done_out,
  output logic idle_slot_out,
  output logic [DATA_W-1:0] acc_out,
  output logic [STAT_W-1:0] status_out
);

  // ****************************************
  // state
  // ****************************************
  abs_state_t state, next_state;
  logic [1:0] phase, next_phase;
  abs_op_t op_q, next_op_q;
  logic [FADDR_W-1:0] addr_q, next_addr_q;
  logic [BIT_W-1:0] bit_q, next_bit_q;
  logic [DATA_W-1:0] lit_q, next_lit_q;
  logic dest_q, next_dest_q;
  logic next_ready;
  logic next_done;
  logic next_idle_slot;
  logic [DATA_W-1:0] acc, next_acc;
  logic [STAT_W-1:0] status, next_status;
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [DATA_W-1:0] next_file_mem [FILE_DEPTH];
  logic [DATA_W-1:0] next_rdata;
  logic commit;

  abs_alu_if alu_bus ();

  abs_alu u_alu (
    .bus(alu_bus.alu)
  );

  // ****************************************
  // operands to the unit
  // ****************************************
  assign alu_bus.op = op_q;
  assign alu_bus.acc = acc;
  assign alu_bus.file_val = file_mem[addr_q];
  assign alu_bus.literal = lit_q;
  assign alu_bus.bit_pos = bit_q;
  assign alu_bus.dest_file = dest_q;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_op_q = op_q;
    next_addr_q = addr_q;
    next_bit_q = bit_q;
    next_lit_q = lit_q;
    next_dest_q = dest_q;
    next_done = 1'b0;
    commit = 1'b0;
    unique case (state)
      ST_IDLE: begin
        // idle cycle is the first period of an instruction
        if (instr_valid_in) begin
          next_op_q = abs_op_t'(instr_op_in);
          next_addr_q = file_addr_in;
          next_bit_q = bit_pos_in;
          next_lit_q = literal_in;
          next_dest_q = dest_file_in;
          next_state = ST_EXEC;
          next_phase = PHASE_FIRST;
        end
      end
      ST_EXEC: begin
        // [RULE10] four period cycle
        if (phase == PHASE_LAST) begin
          commit = 1'b1;
          next_done = 1'b1;
          // [RULE8] [RULE9] enter idle slot
          if (alu_bus.skip) begin
            next_state = ST_SKIP;
            next_phase = 2'h0;
          end else begin
            next_state = ST_IDLE;
          end
        end else begin
          next_phase = phase + 2'h1;
        end
      end
      ST_SKIP: begin
        // [RULE8] [RULE9] discarded slot
        if (phase == PHASE_LAST) begin
          next_state = ST_IDLE;
        end else begin
          next_phase = phase + 2'h1;
        end
      end
    endcase
    next_ready = (next_state == ST_IDLE);
    next_idle_slot = (next_state == ST_SKIP);
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      op_q <= add_literal_acc;
      addr_q <= 7'h00;
      bit_q <= 3'h0;
      lit_q <= 8'h00;
      dest_q <= 1'b0;
      ready_out <= 1'b1;
      done_out <= 1'b0;
      idle_slot_out <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      op_q <= next_op_q;
      addr_q <= next_addr_q;
      bit_q <= next_bit_q;
      lit_q <= next_lit_q;
      dest_q <= next_dest_q;
      ready_out <= next_ready;
      done_out <= next_done;
      idle_slot_out <= next_idle_slot;
    end
  end

  // ****************************************
  // accumulator, flags and file registers
  // ****************************************
  always_comb begin
    next_acc = acc;
    next_status = status;
    next_file_mem = file_mem;
    // software writes first; a commit in the same cycle overrides
    if (bus_write_in) begin
      if (bus_addr_in <= ADDR_FILE_LAST) begin
        next_file_mem[bus_addr_in[FADDR_W-1:0]] = bus_wdata_in;
      end else if (bus_addr_in == ADDR_ACC) begin
        next_acc = bus_wdata_in;
      end else if (bus_addr_in == ADDR_STATUS) begin
        next_status = bus_wdata_in[STAT_W-1:0];
      end
    end
    if (commit) begin
      // [RULE3] result routing
      if (alu_bus.to_acc) begin
        next_acc = alu_bus.result;
      end
      if (alu_bus.to_file) begin
        next_file_mem[addr_q] = alu_bus.result;
      end
      // [RULE11] carry and nibble flags
      if (alu_bus.upd_arith) begin
        next_status[STAT_CARRY] = alu_bus.carry;
        next_status[STAT_NIBBLE] = alu_bus.nibble_overflow;
      end
      // [RULE11] zero flag
      if (alu_bus.upd_zero) begin
        next_status[STAT_ZERO] = alu_bus.zero;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc <= ACC_RESET;
      status <= STATUS_RESET;
      acc_out <= ACC_RESET;
      status_out <= STATUS_RESET;
    end else begin
      acc <= next_acc;
      status <= next_status;
      acc_out <= next_acc;
      status_out <= next_status;
    end
  end

  generate
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          file_mem[i] <= FILE_RESET;
        end else begin
          file_mem[i] <= next_file_mem[i];
        end
      end
    end
  endgenerate

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    if (bus_read_in) begin
      if (bus_addr_in <= ADDR_FILE_LAST) begin
        next_rdata = file_mem[bus_addr_in[FADDR_W-1:0]];
      end else if (bus_addr_in == ADDR_ACC) begin
        next_rdata = acc;
      end else if (bus_addr_in == ADDR_STATUS) begin
        next_rdata = {5'h00, status};
      end else if (bus_addr_in == ADDR_CORE_STATE) begin
        next_rdata[CORE_BUSY] = (state != ST_IDLE);
        next_rdata[CORE_IDLE_SLOT] = (state == ST_SKIP);
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_rdata_out <= 8'h00;
    end else begin
      bus_rdata_out <= next_rdata;
    end
  end

endmodule

// ### tb/abs_exec_monitor.sv
// checker for accept, commit and skip timing of the execute block
// assumes abs_pkg is compiled and the block is bound by name
`timescale 1ns/100ps
module abs_exec_monitor
  import abs_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] instr_op_in,
  input wire logic [DATA_W-1:0] literal_in,
  input wire logic [BUS_ADDR_W-1:0] bus_addr_in,
  input wire logic bus_read_in,
  input wire logic [DATA_W-1:0] bus_rdata_out,
  input wire logic ready_out,
  input wire logic done_out,
  input wire logic idle_slot_out,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic [STAT_W-1:0] status_out
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic take;
  assign take = instr_valid_in && ready_out;

  a_take_busy: assert property (take |=> !ready_out)
    else $error("ready stays high after accept");
  a_done_time: assert property (take |=> !done_out [*3] ##1 done_out)
    else $error("done not four clocks after accept");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_skip_slot: assert property (done_out && idle_slot_out |->
    (idle_slot_out && !ready_out) [*4] ##1 (!idle_slot_out && ready_out))
    else $error("skip slot not four clocks");
  a_plain_end: assert property (done_out && !idle_slot_out |-> ready_out)
    else $error("not ready after plain instruction");
  a_add_lit: assert property (take && instr_op_in == 3'h0 |-> ##4
    {status_out[STAT_CARRY], acc_out} ==
    {1'b0, $past(acc_out, 4)} + $past(literal_in, 4))
    else $error("literal sum or carry wrong");
  a_and_lit: assert property (take && instr_op_in == 3'h2 |-> ##4
    acc_out == ($past(acc_out, 4) & $past(literal_in, 4)) &&
    status_out[STAT_ZERO] == (acc_out == 8'h00) &&
    status_out[1:0] == $past(status_out[1:0], 4))
    else $error("literal and result or flags wrong");
  a_bit_flags: assert property (take && instr_op_in[2] |-> ##4
    status_out == $past(status_out, 4))
    else $error("bit or skip op changed flags");
  a_rdata_zero: assert property (!bus_read_in |=> bus_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_acc_read: assert property (bus_read_in && bus_addr_in == ADDR_ACC |=>
    bus_rdata_out == $past(acc_out))
    else $error("accumulator read mismatch");
endmodule

bind add_and_bit_skip_execute abs_exec_monitor i_abs_exec_monitor (
  .clock_in, .reset_n_in, .instr_valid_in, .instr_op_in, .literal_in,
  .bus_addr_in, .bus_read_in, .bus_rdata_out, .ready_out, .done_out,
  .idle_slot_out, .acc_out, .status_out);

// ### tb/add_and_bit_skip_execute_test.sv
// self-checking bench for the add/and/bit/skip execute block
// assumes abs_pkg, the design and the monitor are compiled first
`timescale 1ns/100ps
module add_and_bit_skip_execute_test;
  import abs_pkg::*;
  // ****************************************
  // stimulus and model state
  // ****************************************
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [2:0] instr_op_in = 3'h0;
  logic [FADDR_W-1:0] file_addr_in = 7'h00;
  logic [BIT_W-1:0] bit_pos_in = 3'h0;
  logic [DATA_W-1:0] literal_in = 8'h00;
  logic dest_file_in = 1'b0;
  logic [BUS_ADDR_W-1:0] bus_addr_in = 8'h00;
  logic [DATA_W-1:0] bus_wdata_in = 8'h00;
  logic bus_write_in = 1'b0;
  logic bus_read_in = 1'b0;
  logic [DATA_W-1:0] bus_rdata_out, acc_out;
  logic ready_out, done_out, idle_slot_out;
  logic [STAT_W-1:0] status_out;
  logic [7:0] m_acc, rv;
  logic [7:0] m_mem [128];
  logic [2:0] m_st;
  int err_count = 0;
  int checks = 0;

  add_and_bit_skip_execute i_add_and_bit_skip_execute (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .instr_valid_in(instr_valid_in),
    .instr_op_in(instr_op_in),
    .file_addr_in(file_addr_in),
    .bit_pos_in(bit_pos_in),
    .literal_in(literal_in),
    .dest_file_in(dest_file_in),
    .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in),
    .bus_write_in(bus_write_in),
    .bus_read_in(bus_read_in),
    .bus_rdata_out(bus_rdata_out),
    .ready_out(ready_out),
    .done_out(done_out),
    .idle_slot_out(idle_slot_out),
    .acc_out(acc_out),
    .status_out(status_out)
  );

  always #25 clock_in = ~clock_in;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst;
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    foreach (m_mem[i]) m_mem[i] = 8'h00;
    m_acc = 8'h00;
    m_st = 3'h0;
    repeat (2) @(posedge clock_in);
    #1 chk({5'h0, ready_out, done_out, idle_slot_out}, 8'h04);
    chk(acc_out, 8'h00);
    chk({5'h0, status_out}, 8'h00);
    @(posedge clock_in);
    reset_n_in <= 1'b1;
    $display("test reset done");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_write_in <= 1'b1;
    @(posedge clock_in);
    bus_write_in <= 1'b0;
    if (a == ADDR_ACC) m_acc = d;
    else if (a == ADDR_STATUS) m_st = d[2:0];
    else if (!a[7]) m_mem[a[6:0]] = d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_read_in <= 1'b1;
    @(posedge clock_in);
    bus_read_in <= 1'b0;
    #1 d = bus_rdata_out;
  endtask

  task automatic exec(input logic [2:0] op, input logic [6:0] f,
    input logic [2:0] b, input logic [7:0] k, input logic d);
    logic [8:0] s;
    logic [7:0] r;
    logic skip;
    r = op[0] ? m_mem[f] : k;
    skip = 1'b0;
    @(posedge clock_in);
    instr_op_in <= op;
    file_addr_in <= f;
    bit_pos_in <= b;
    literal_in <= k;
    dest_file_in <= d;
    instr_valid_in <= 1'b1;
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    if (!op[2]) begin
      s = op[1] ? {1'b0, m_acc & r} : m_acc + r;
      if (!op[1]) m_st[1:0] = {(m_acc[3:0] + r[3:0]) > 5'hF, s[8]};
      m_st[2] = s[7:0] == 8'h00;
      if (op[0] && d) m_mem[f] = s[7:0];
      else m_acc = s[7:0];
    end else if (!op[1]) m_mem[f][b] = op[0];
    else skip = m_mem[f][b] == !op[0];
    repeat (3) @(posedge clock_in);
    #1 chk({7'h0, done_out}, 8'h01);
    chk(acc_out, m_acc);
    chk({5'h0, status_out}, {5'h0, m_st});
    chk({6'h0, idle_slot_out, ready_out}, {6'h0, skip, !skip});
    if (skip) begin
      // offered during the slot, must be dropped
      @(posedge clock_in);
      instr_op_in <= 3'h0;
      literal_in <= 8'h5A;
      instr_valid_in <= 1'b1;
      @(posedge clock_in);
      instr_valid_in <= 1'b0;
      // core state read in the last slot cycle: busy and in slot
      rd(ADDR_CORE_STATE, rv);
      chk(rv, 8'h03);
      chk({6'h0, idle_slot_out, ready_out}, 8'h01);
    end
    rd({1'b0, f}, rv);
    chk(rv, m_mem[f]);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(94243));
    rst();
    wr(ADDR_FILE_LAST, 8'hA5);
    wr(8'h90, 8'h3C);
    rd(ADDR_FILE_LAST, rv);
    chk(rv, 8'hA5);
    rd(8'h90, rv);
    chk(rv, 8'h00);
    rd(ADDR_CORE_STATE, rv);
    chk(rv, 8'h00);
    wr(ADDR_STATUS, 8'hFD);
    rd(ADDR_STATUS, rv);
    chk(rv, 8'h05);
    $display("test registers done");
    wr(ADDR_ACC, 8'hFF);
    exec(3'h0, 7'h00, 3'h0, 8'h01, 1'b1);
    wr(ADDR_ACC, 8'h0F);
    exec(3'h1, 7'h7F, 3'h0, 8'h00, 1'b1);
    exec(3'h2, 7'h00, 3'h0, 8'hF0, 1'b0);
    rd(ADDR_ACC, rv);
    chk(rv, m_acc);
    $display("test corners done");
    for (int i = 0; i < 16; i++) begin
      exec(i[3:1], 7'h7F, 3'h7, 8'($urandom), i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(i), 8'($urandom));
    end
    repeat (80) begin
      exec(3'($urandom), 7'($urandom % 4), 3'($urandom), 8'($urandom),
        1'($urandom));
    end
    $display("test random done");
    rst();
    rd(8'h01, rv);
    chk(rv, 8'h00);
    test_done();
  end

  // about twenty-five times the expected run
  initial begin
    #1000000;
    err_count++;
    test_done();
  end
endmodule
